// >>> pkg/isrs_pkg.sv
package isrs_pkg;
  // ********************************************************************
  // Register numbers and reset values
  // ********************************************************************
  localparam logic [3:0]  ADDR_SEQ_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_PIX_COUNT  = 4'h1;
  localparam logic [3:0]  ADDR_LINE_COUNT = 4'h2;
  localparam logic [3:0]  ADDR_INT_COUNT  = 4'h3;
  localparam logic [11:0] RST_SEQ_CTRL    = 12'h100;
  localparam logic [10:0] RST_PIX_COUNT   = 11'h200;
  localparam logic [11:0] RST_LINE_COUNT  = 12'hBC6;
  localparam logic [11:0] RST_INT_COUNT   = 12'h001;

  // ********************************************************************
  // Field positions of the sequencer control register
  // ********************************************************************
  localparam int BIT_NDR_SELECT  = 0;
  localparam int BIT_SUBMODE_LO  = 1;
  localparam int BIT_SUBMODE_HI  = 2;
  localparam int BIT_RESET_BLACK = 3;
  localparam int BIT_FAST_RESET  = 4;
  localparam int BIT_FRAME_CAL   = 5;
  localparam int BIT_LINE_CAL    = 6;
  localparam int BIT_CONTINUOUS_COLUMN_CHARGING = 7;
  localparam int BIT_GRAN_LO     = 8;
  localparam int BIT_GRAN_HI     = 9;
  localparam int BIT_BLACK       = 10;
  localparam int BIT_RESET_ALL   = 11;

  // ********************************************************************
  // Nondestructive submode codes and timing
  // ********************************************************************
  localparam logic [1:0] SUB_M1_RESET = 2'h0;
  localparam logic [1:0] SUB_M2_RESET = 2'h2;
  localparam logic [1:0] GRAN_2       = 2'h0;
  localparam logic [1:0] GRAN_4       = 2'h1;
  localparam logic [1:0] GRAN_8       = 2'h2;
  localparam logic [10:0] BLANK_G2    = 11'h08E;  // 142 clocks
  localparam logic [10:0] BLANK_G4    = 11'h11A;  // 282 clocks
  localparam logic [10:0] BLANK_G8    = 11'h232;  // 562 clocks
  localparam logic [10:0] BLANK_G16   = 11'h462;  // 1122 clocks
  localparam logic [4:0]  DIV_G2      = 5'h02;
  localparam logic [4:0]  DIV_G4      = 5'h04;
  localparam logic [4:0]  DIV_G8      = 5'h08;
  localparam logic [4:0]  DIV_G16     = 5'h10;
  localparam int          PIX_W       = 11;
  localparam int          LINE_W      = 12;
  localparam int          ROW_W       = 12;
  localparam int          START_W     = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_BLANK, ST_PIXELS} isrs_state_t;
endpackage

// >>> core/isrs_buf.sv
`timescale 1ns/10ps
`default_nettype none
module isrs_buf #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [1:0]   count_ff;
  logic [W-1:0] skid_ff;
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign o_in_ready = (count_ff != 2'h2);
  assign push       = i_in_valid & o_in_ready;
  assign pop        = o_out_valid & i_out_ready;

  // Head register feeds the port, skid holds the second word
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_ff    <= 2'h0;
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
      skid_ff     <= '0;
    end else if (i_clk_en) begin
      if (push && (count_ff == 2'h0 || (count_ff == 2'h1 && pop))) begin
        o_out_data <= i_in_data;
      end else if (pop && count_ff == 2'h2) begin
        o_out_data <= skid_ff;
      end
      if (push && count_ff == 2'h1 && !pop) begin
        skid_ff <= i_in_data;
      end
      if (push && !pop) begin
        count_ff    <= count_ff + 2'h1;
        o_out_valid <= 1'b1;
      end else if (pop && !push) begin
        count_ff    <= count_ff - 2'h1;
        o_out_valid <= (count_ff == 2'h2);
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/isrs_sequencer.sv
// Notes on behaviour
// (R01) Readout bit low: sample, reset, sample again
// (R02) Submode bits act only in nondestructive readout
// (R03) Mode 1: left/right rows tied, no shutter
// (R04) Mode 2: rows alternate left and right pointer
// (R05) Mode 2 reset frame: reset left, not right
// (R06) Mode 2 read frame: reset neither row
// (R07) Nondestructive: reset buses driven to dark level
// (R08) Reset-before-read resets each row, except mode-2 right
// (R09) Fast reset drives both shift registers identically
// (R10) Calibrate each blanking; frame bit chooses mode on first mode-2 line, line bit otherwise
// (R11) Continuous-charge bit selects continuous column charging
// (R12) Column clock runs at half system rate
// (R13) Granularity sets blanking 142/282/562/1122 clocks
// (R14) Black bit holds black signal high
// (R15) Reset-all bit holds all pixels in reset
// (R16) Pixel-valid until count reached, then end-of-line
// (R17) Line counter ends frame; mode 2 every second
// (R18) Integration counter reaching setting loads right pointer
// (R19) Integration is lines minus integration plus one
// (R20) Controller holds line clock one, frame start three
// (R21) Inputs change only on rising clock, glitch-free
// (R22) Counters cleared at their sync before counting
`timescale 1ns/10ps
`default_nettype none
module isrs_sequencer (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  // Register write and read port
  input  wire logic        i_reg_wr,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [11:0] i_reg_wdata,
  output logic [11:0]      o_reg_rdata,
  // Controller pulses and window start row
  input  wire logic        i_line_clk,
  input  wire logic        i_frame_start,
  input  wire logic [7:0]  i_row_start,
  // Pixel stream
  output logic             o_pix_valid,
  input  wire logic        i_pix_ready,
  output logic [10:0]      o_pix_col,
  output logic             o_end_of_line_pulse,
  output logic             o_end_of_frame,
  // Row addressing
  output logic             o_left_pointer_sync,
  output logic             o_right_pointer_sync,
  output logic [11:0]      o_left_row,
  output logic [11:0]      o_right_row,
  output logic             o_read_right,
  output logic             o_row_reset,
  output logic             o_rows_tied,
  // Analog control levels
  output logic             o_double_sample,
  output logic             o_reset_bus_dark,
  output logic             o_black,
  output logic             o_reset_all,
  output logic             o_continuous_column_charging,
  output logic             o_cal_active,
  output logic             o_cal_slow,
  output logic             o_xseq_clk,
  output logic             o_col_clk
);
  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [11:0] seq_ctrl_ff;
  logic [10:0] pix_count_ff;
  logic [11:0] line_count_ff;
  logic [11:0] int_count_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_ctrl_ff   <= isrs_pkg::RST_SEQ_CTRL;
      pix_count_ff  <= isrs_pkg::RST_PIX_COUNT;
      line_count_ff <= isrs_pkg::RST_LINE_COUNT;
      int_count_ff  <= isrs_pkg::RST_INT_COUNT;
    end else if (i_clk_en && i_reg_wr) begin
      if (i_reg_addr == isrs_pkg::ADDR_SEQ_CTRL) begin
        seq_ctrl_ff <= i_reg_wdata;
      end else if (i_reg_addr == isrs_pkg::ADDR_PIX_COUNT) begin
        pix_count_ff <= i_reg_wdata[10:0];
      end else if (i_reg_addr == isrs_pkg::ADDR_LINE_COUNT) begin
        line_count_ff <= i_reg_wdata;
      end else if (i_reg_addr == isrs_pkg::ADDR_INT_COUNT) begin
        int_count_ff <= i_reg_wdata;
      end
    end
  end

  // Decoded mode fields
  logic       nondestructive_readout_select;
  logic [1:0] submode;
  logic       mode1;
  logic       mode2;
  logic [1:0] gran;
  assign nondestructive_readout_select     = seq_ctrl_ff[isrs_pkg::BIT_NDR_SELECT];
  assign submode = {seq_ctrl_ff[isrs_pkg::BIT_SUBMODE_HI], seq_ctrl_ff[isrs_pkg::BIT_SUBMODE_LO]};
  assign mode1   = nondestructive_readout_select & ~submode[1];  // [R02]
  assign mode2   = nondestructive_readout_select & submode[1];   // [R02]
  assign gran    = {seq_ctrl_ff[isrs_pkg::BIT_GRAN_HI], seq_ctrl_ff[isrs_pkg::BIT_GRAN_LO]};

  // Blanking length for a granularity code
  function automatic logic [10:0] blank_len(input logic [1:0] g);
    if (g == isrs_pkg::GRAN_2)      blank_len = isrs_pkg::BLANK_G2;
    else if (g == isrs_pkg::GRAN_4) blank_len = isrs_pkg::BLANK_G4;
    else if (g == isrs_pkg::GRAN_8) blank_len = isrs_pkg::BLANK_G8;
    else                            blank_len = isrs_pkg::BLANK_G16;
  endfunction

  // X-sequencer clock divisor for a granularity code
  function automatic logic [4:0] xseq_div(input logic [1:0] g);
    if (g == isrs_pkg::GRAN_2)      xseq_div = isrs_pkg::DIV_G2;
    else if (g == isrs_pkg::GRAN_4) xseq_div = isrs_pkg::DIV_G4;
    else if (g == isrs_pkg::GRAN_8) xseq_div = isrs_pkg::DIV_G8;
    else                            xseq_div = isrs_pkg::DIV_G16;
  endfunction

  // Register readback
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 12'h000;
    end else if (i_clk_en) begin
      if (i_reg_addr == isrs_pkg::ADDR_SEQ_CTRL) begin
        o_reg_rdata <= seq_ctrl_ff;
      end else if (i_reg_addr == isrs_pkg::ADDR_PIX_COUNT) begin
        o_reg_rdata <= {1'b0, pix_count_ff};
      end else if (i_reg_addr == isrs_pkg::ADDR_LINE_COUNT) begin
        o_reg_rdata <= line_count_ff;
      end else if (i_reg_addr == isrs_pkg::ADDR_INT_COUNT) begin
        o_reg_rdata <= int_count_ff;
      end else begin
        o_reg_rdata <= 12'h000;
      end
    end
  end

  // ********************************************************************
  // Edge detection of controller pulses
  // ********************************************************************
  logic line_clk_d_ff;
  logic frame_start_d_ff;
  logic line_rise;
  logic frame_rise;

  // Inputs are sampled on the rising clock edge only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_clk_d_ff    <= 1'b0;
      frame_start_d_ff <= 1'b0;
    end else if (i_clk_en) begin
      line_clk_d_ff    <= i_line_clk;     // [R21]
      frame_start_d_ff <= i_frame_start;  // [R21]
    end
  end
  assign line_rise  = i_line_clk & ~line_clk_d_ff;
  assign frame_rise = i_frame_start & ~frame_start_d_ff;

  // ********************************************************************
  // Frame, line and integration counting
  // ********************************************************************
  logic [11:0] line_cnt_ff;
  logic [11:0] int_cnt_ff;
  logic        phase_ff;
  logic        right_live_ff;
  logic        first_row_ff;
  logic        step;
  assign step = line_rise & (~mode2 | phase_ff);  // [R17] [R18]

  // Counters and pointers; lines - int + 1 set the integration
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_cnt_ff          <= 12'h000;
      int_cnt_ff           <= 12'h000;
      phase_ff             <= 1'b0;
      right_live_ff        <= 1'b0;
      first_row_ff         <= 1'b0;
      o_left_row           <= 12'h000;
      o_right_row          <= 12'h000;
      o_left_pointer_sync  <= 1'b0;
      o_right_pointer_sync <= 1'b0;
      o_end_of_frame       <= 1'b0;
      o_read_right         <= 1'b0;
    end else if (i_clk_en) begin
      o_left_pointer_sync  <= 1'b0;
      o_right_pointer_sync <= 1'b0;
      o_end_of_frame       <= 1'b0;
      if (frame_rise) begin
        line_cnt_ff         <= 12'h000;  // [R22]
        int_cnt_ff          <= 12'h000;  // [R22]
        phase_ff            <= 1'b0;
        right_live_ff       <= 1'b0;
        first_row_ff        <= 1'b1;
        o_left_row          <= {4'h0, i_row_start};  // [R18]
        o_left_pointer_sync <= 1'b1;                  // [R18]
      end else if (line_rise) begin
        if (mode2) begin
          phase_ff <= ~phase_ff;  // [R04]
        end
        o_read_right <= mode2 & phase_ff;  // [R04]
        if (step) begin
          first_row_ff <= 1'b0;
          line_cnt_ff  <= line_cnt_ff + 12'h001;  // [R17]
          if (line_cnt_ff == line_count_ff) begin
            o_end_of_frame <= 1'b1;  // [R17]
          end
          o_left_row <= o_left_row + 12'h001;  // [R18]
          if (int_cnt_ff == int_count_ff && !right_live_ff) begin
            right_live_ff        <= 1'b1;
            o_right_row          <= {4'h0, i_row_start};  // [R18] [R19]
            o_right_pointer_sync <= 1'b1;                  // [R18]
          end else begin
            int_cnt_ff <= int_cnt_ff + 12'h001;  // [R18]
            if (right_live_ff) begin
              o_right_row <= o_right_row + 12'h001;
            end
          end
        end
      end
    end
  end

  // ********************************************************************
  // Row operation per line clock
  // ********************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_row_reset <= 1'b0;
    end else if (i_clk_en && line_rise) begin
      if (!nondestructive_readout_select) begin
        o_row_reset <= 1'b1;  // [R01]
      end else if (mode2 && phase_ff) begin
        o_row_reset <= 1'b0;  // [R05] [R06] [R08]
      end else if (seq_ctrl_ff[isrs_pkg::BIT_RESET_BLACK]) begin
        o_row_reset <= 1'b1;  // [R08]
      end else if (mode2) begin
        o_row_reset <= (submode == isrs_pkg::SUB_M2_RESET);  // [R05] [R06]
      end else begin
        o_row_reset <= (submode == isrs_pkg::SUB_M1_RESET);  // [R03]
      end
    end
  end

  // Static levels from mode bits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rows_tied                  <= 1'b0;
      o_double_sample              <= 1'b0;
      o_reset_bus_dark             <= 1'b0;
      o_black                      <= 1'b0;
      o_reset_all                  <= 1'b0;
      o_continuous_column_charging <= 1'b0;
    end else if (i_clk_en) begin
      o_rows_tied      <= mode1 | seq_ctrl_ff[isrs_pkg::BIT_FAST_RESET];  // [R03] [R09]
      o_double_sample  <= 1'b1;                                            // [R01] [R07]
      o_reset_bus_dark <= nondestructive_readout_select | seq_ctrl_ff[isrs_pkg::BIT_BLACK];          // [R07] [R14]
      o_black          <= seq_ctrl_ff[isrs_pkg::BIT_BLACK];                // [R14]
      o_reset_all      <= seq_ctrl_ff[isrs_pkg::BIT_RESET_ALL];            // [R15]
      o_continuous_column_charging <= seq_ctrl_ff[isrs_pkg::BIT_CONTINUOUS_COLUMN_CHARGING];  // [R11]
    end
  end

  // ********************************************************************
  // Row sequencer: suspend, blanking, pixel readout
  // ********************************************************************
  isrs_pkg::isrs_state_t state_ff;
  logic [10:0] blank_cnt_ff;
  logic [10:0] pix_cnt_ff;
  logic        half_ff;
  logic        buf_ready;
  logic        buf_push;
  logic        last_pix;
  assign buf_push = (state_ff == isrs_pkg::ST_PIXELS) & half_ff & buf_ready;
  assign last_pix = (pix_cnt_ff == pix_count_ff);

  // Suspended while the line clock is high, then blank and read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff            <= isrs_pkg::ST_IDLE;
      blank_cnt_ff        <= 11'h000;
      pix_cnt_ff          <= 11'h000;
      half_ff             <= 1'b0;
      o_end_of_line_pulse <= 1'b0;
      o_cal_active        <= 1'b0;
      o_cal_slow          <= 1'b0;
    end else if (i_clk_en) begin
      o_end_of_line_pulse <= 1'b0;
      case (state_ff)
        isrs_pkg::ST_IDLE: begin
          if (i_line_clk) begin
            state_ff <= isrs_pkg::ST_HOLD;  // [R20]
          end
        end
        isrs_pkg::ST_HOLD: begin
          if (!i_line_clk) begin
            state_ff     <= isrs_pkg::ST_BLANK;
            blank_cnt_ff <= blank_len(gran) - 11'h001;  // [R13]
            o_cal_active <= 1'b1;                       // [R10]
            o_cal_slow   <= first_row_ff ? seq_ctrl_ff[isrs_pkg::BIT_FRAME_CAL]
                                         : seq_ctrl_ff[isrs_pkg::BIT_LINE_CAL];  // [R10]
          end
        end
        isrs_pkg::ST_BLANK: begin
          if (i_line_clk) begin
            state_ff     <= isrs_pkg::ST_HOLD;  // [R20]
            o_cal_active <= 1'b0;
          end else if (blank_cnt_ff == 11'h000) begin
            state_ff     <= isrs_pkg::ST_PIXELS;
            pix_cnt_ff   <= 11'h000;  // [R22]
            half_ff      <= 1'b0;
            o_cal_active <= 1'b0;
          end else begin
            blank_cnt_ff <= blank_cnt_ff - 11'h001;  // [R13]
          end
        end
        isrs_pkg::ST_PIXELS: begin
          if (i_line_clk) begin
            state_ff <= isrs_pkg::ST_HOLD;
          end else begin
            if (!half_ff || buf_ready) begin
              half_ff <= ~half_ff;  // [R12]
            end
            if (buf_push) begin
              pix_cnt_ff <= pix_cnt_ff + 11'h001;  // [R16]
              if (last_pix) begin
                o_end_of_line_pulse <= 1'b1;  // [R16]
                state_ff            <= isrs_pkg::ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_ff <= isrs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // Divided clocks
  // ********************************************************************
  logic [4:0] xdiv_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xdiv_ff    <= 5'h00;
      o_xseq_clk <= 1'b0;
      o_col_clk  <= 1'b0;
    end else if (i_clk_en) begin
      xdiv_ff    <= xdiv_ff + 5'h01;
      o_xseq_clk <= (xdiv_ff & ((xseq_div(gran) >> 1) - 5'h01)) == 5'h00 ? ~o_xseq_clk
                                                                        : o_xseq_clk;  // [R13]
      o_col_clk  <= (state_ff == isrs_pkg::ST_PIXELS) & ~half_ff;  // [R12]
    end
  end

  // ********************************************************************
  // Column-pair stream buffer
  // ********************************************************************
  isrs_buf #(
    .W (isrs_pkg::PIX_W)
  ) u_buf (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  ((state_ff == isrs_pkg::ST_PIXELS) & half_ff & ~i_line_clk),
    .o_in_ready  (buf_ready),
    .i_in_data   (pix_cnt_ff),
    .o_out_valid (o_pix_valid),
    .i_out_ready (i_pix_ready),
    .o_out_data  (o_pix_col)
  );
endmodule
`default_nettype wire

// >>> tb/isrs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module isrs_checker (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_clk_en,
  // Register port
  input wire logic        i_reg_wr,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [11:0] i_reg_wdata,
  // Controller and stream
  input wire logic        i_line_clk,
  input wire logic        i_frame_start,
  input wire logic [7:0]  i_row_start,
  input wire logic        i_pix_ready,
  input wire logic        o_pix_valid,
  input wire logic [10:0] o_pix_col,
  input wire logic        o_end_of_line_pulse,
  input wire logic        o_left_pointer_sync,
  input wire logic [11:0] o_left_row,
  input wire logic        o_cal_active,
  // Levels
  input wire logic        o_rows_tied,
  input wire logic        o_double_sample,
  input wire logic        o_reset_bus_dark,
  input wire logic        o_black,
  input wire logic        o_reset_all,
  input wire logic        o_continuous_column_charging
);
  // ********
  // Helper logic
  // ********
  logic [11:0] ctrl_ff;
  logic        en_seen_ff;
  // Control register shadow
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_ff <= isrs_pkg::RST_SEQ_CTRL;
    end else if (i_clk_en && i_reg_wr && i_reg_addr == isrs_pkg::ADDR_SEQ_CTRL) begin
      ctrl_ff <= i_reg_wdata;
    end
  end
  // First enabled edge seen
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_seen_ff <= 1'b0;
    end else begin
      en_seen_ff <= en_seen_ff | i_clk_en;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Control stable two cycles
  sequence s_ctrl_settled;
    ctrl_ff == $past(ctrl_ff) && ctrl_ff == $past(ctrl_ff, 2);
  endsequence
  // Frame start seen rising
  sequence s_frame_rise;
    i_clk_en && i_frame_start && !$past(i_frame_start);
  endsequence
  // ********
  // Assertions
  // ********
  a_double_sample_on: assert property (en_seen_ff |-> o_double_sample)
    else $error("double sample low");
  a_dark_bus_level: assert property (s_ctrl_settled |-> o_reset_bus_dark == (ctrl_ff[0] | ctrl_ff[10]))
    else $error("dark bus wrong");
  a_rows_tied_mode: assert property (s_ctrl_settled |-> o_rows_tied == (ctrl_ff[4] | (ctrl_ff[0] & !ctrl_ff[2])))
    else $error("row tie wrong");
  a_continuous_column_charging_mirror: assert property (s_ctrl_settled |-> o_continuous_column_charging == ctrl_ff[7])
    else $error("charge wrong");
  a_black_mirror: assert property (s_ctrl_settled |-> o_black == ctrl_ff[10])
    else $error("black wrong");
  a_reset_all_mirror: assert property (s_ctrl_settled |-> o_reset_all == ctrl_ff[11])
    else $error("reset-all wrong");
  a_frame_left_load: assert property (s_frame_rise |=> o_left_pointer_sync && o_left_row == {4'h0, $past(i_row_start)})
    else $error("left load wrong");
  a_left_sync_pulse: assert property (o_left_pointer_sync |=> !o_left_pointer_sync)
    else $error("left sync long");
  a_hold_suspends: assert property (i_clk_en && i_line_clk |=> !o_cal_active && !o_end_of_line_pulse)
    else $error("not suspended");
  a_blank_min_span: assert property ($rose(o_cal_active) |-> o_cal_active [*8])
    else $error("blanking too short");
  a_stall_holds_word: assert property (i_clk_en && o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_col))
    else $error("stall lost word");
endmodule
bind isrs_sequencer isrs_checker i_isrs_checker (.*);
`default_nettype wire

// >>> tb/isrs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module isrs_ctrl_model (
  // Clock
  input  wire logic i_clk,
  // Requests from the bench
  input  wire logic i_frame_req,
  input  wire logic i_line_req,
  // Pulses to the sequencer
  output logic      o_frame_start,
  output logic      o_line_clk
);
  int fs_cnt = 0;
  int lc_cnt = 0;
  // Counters step on the rising edge only
  always @(posedge i_clk) begin
    fs_cnt <= i_frame_req ? 3 : (fs_cnt > 0 ? fs_cnt - 1 : 0); // Three cycles
    lc_cnt <= i_line_req ? 2 : (lc_cnt > 0 ? lc_cnt - 1 : 0); // At least one cycle
  end
  // Levels follow the counters
  assign o_frame_start = (fs_cnt > 0);
  assign o_line_clk    = (lc_cnt > 0);
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ********
  // Signals
  // ********
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_clk_en = 1'b1;
  logic        i_reg_wr = 1'b0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [11:0] i_reg_wdata = 12'h000;
  logic [7:0]  i_row_start = 8'h00;
  logic        i_pix_ready = 1'b1;
  logic        frame_req = 1'b0;
  logic        line_req = 1'b0;
  wire logic   line_clk;
  wire logic   frame_start;
  logic [11:0] rdata, lrow, rrow;
  logic [10:0] col;
  logic        pv, end_of_line_pulse, eof, rsync, rd_right, row_rst, cal;
  int          fails = 0;
  int          n_compared = 0;
  int          seed = 40;
  int          rises = 0;
  int          eof_at = 0;
  int          rs_at = 0;
  logic [11:0] rs_row = 12'h000;
  int          bl [4] = '{142, 282, 562, 1122};
  logic [11:0] cfg [8] = '{12'h000, 12'h001, 12'h003, 12'h005,
                           12'h007, 12'h00B, 12'h00F, 12'h010};
  always #20 i_clk = ~i_clk;
  // Design and controller
  isrs_ctrl_model i_isrs_ctrl_model (.i_clk(i_clk), .i_frame_req(frame_req),
    .i_line_req(line_req), .o_frame_start(frame_start), .o_line_clk(line_clk));
  isrs_sequencer i_isrs_sequencer (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(rdata), .i_line_clk(line_clk), .i_frame_start(frame_start),
    .i_row_start(i_row_start), .o_pix_valid(pv), .i_pix_ready(i_pix_ready), .o_pix_col(col),
    .o_end_of_line_pulse(end_of_line_pulse), .o_end_of_frame(eof), .o_left_pointer_sync(),
    .o_right_pointer_sync(rsync), .o_left_row(lrow), .o_right_row(rrow),
    .o_read_right(rd_right), .o_row_reset(row_rst), .o_rows_tied(), .o_double_sample(),
    .o_reset_bus_dark(), .o_black(), .o_reset_all(), .o_continuous_column_charging(),
    .o_cal_active(cal), .o_cal_slow(), .o_xseq_clk(), .o_col_clk());
  // Line clock count at frame pulses
  always @(posedge i_clk) begin
    if (eof === 1'b1) eof_at <= rises;
    if (rsync === 1'b1) begin
      rs_at  <= rises;
      rs_row <= rrow;
    end
  end
  // ********
  // Tasks
  // ********
  task tally_and_finish;
    $display("compared %0d, fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task timeout;
    fails++;
    tally_and_finish;
  endtask
  task tick;
    @(posedge i_clk);
    #2;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [11:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick;
    i_reg_wr = 1'b0;
    tick;
  endtask
  task rd_chk(input logic [3:0] a, input logic [11:0] exp);
    i_reg_addr = a;
    tick;
    tick;
    chk(rdata, exp);
  endtask
  task frame;
    i_row_start = 8'($random(seed));
    frame_req = 1'b1;
    tick;
    frame_req = 1'b0;
    repeat (6) tick;
    chk(lrow, {4'h0, i_row_start});
    rises = 0;
    eof_at = 0;
    rs_at = 0;
  endtask
  // Expected row reset of a line
  function automatic logic exp_rst(input logic [11:0] c, input logic right);
    if (!c[0]) return 1'b1;
    if (right) return 1'b0;
    return c[3] | !c[1];
  endfunction
  // One line: clock, blanking, words with stalls
  task run_line(input logic right, input logic rst, input int b);
    int n, k, bc;
    logic seen;
    rises++;
    line_req = 1'b1;
    tick;
    line_req = 1'b0;
    n = 0;
    while (cal !== 1'b1) begin
      tick;
      n++;
      if (n > 20) timeout;
    end
    chk(12'(rd_right), 12'(right));
    chk(12'(row_rst), 12'(rst));
    bc = 0;
    while (cal === 1'b1) begin
      bc++;
      tick;
      if (bc > 1500) timeout;
    end
    if (b != 0) chk(12'(bc), 12'(b));
    k = 0;
    n = 0;
    seen = 1'b0;
    while (!seen || pv === 1'b1) begin
      i_pix_ready = 1'($random(seed));
      if (pv === 1'b1 && i_pix_ready === 1'b1) begin
        chk(12'(col), 12'(k));
        k++;
      end
      if (end_of_line_pulse === 1'b1) seen = 1'b1;
      tick;
      n++;
      if (n > 4000) timeout;
    end
    chk(12'(k), 12'h002);
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    int m2, nl;
    repeat (8) @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    tick;
    rd_chk(4'h0, isrs_pkg::RST_SEQ_CTRL);
    rd_chk(4'h1, {1'b0, isrs_pkg::RST_PIX_COUNT});
    rd_chk(4'h2, isrs_pkg::RST_LINE_COUNT);
    rd_chk(4'h3, isrs_pkg::RST_INT_COUNT);
    wr(4'h5, 12'hFFF);
    rd_chk(4'h5, 12'h000);
    i_clk_en = 1'b0;
    wr(4'h1, 12'h055);
    i_clk_en = 1'b1;
    rd_chk(4'h1, {1'b0, isrs_pkg::RST_PIX_COUNT});
    wr(4'h1, 12'($random(seed)));
    rd_chk(4'h1, {1'b0, i_reg_wdata[10:0]});
    wr(4'h1, 12'h001);
    wr(4'h2, 12'h003);
    wr(4'h3, 12'h001);
    for (int g = 0; g < 4; g++) begin
      wr(4'h0, 12'(g << 8));
      frame;
      run_line(1'b0, 1'b1, bl[g]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, cfg[c]);
      frame;
      m2 = cfg[c][0] & cfg[c][2];
      nl = m2 ? 8 : 4;
      for (int l = 1; l <= nl; l++) begin
        run_line(1'(m2 & ~l), exp_rst(cfg[c], 1'(m2 & ~l)), 0);
      end
      chk(12'(eof_at), 12'(nl));
      chk(12'(rs_at), 12'(m2 ? 4 : 2));
      chk(rs_row, {4'h0, i_row_start});
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
